// ### core/tmc_timer.sv
/*
  8-bit timer counter with two compare channels, Normal and
  clear-on-compare counting, flags, interrupt requests and an
  AXI4-Lite register slave.
  Assumes timer_tick_in is a one-cycle enable from an outside prescaler.
*/
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

// What this block does
// [RL1] Equal count and compare value sets that channel's flag on next tick.
// [RL2] A set flag with its enable raises that channel's interrupt request.
// [RL3] Flag clears on interrupt service or software write of one.
// [RL4] Compare values double buffered in PWM modes, direct otherwise.
// [RL5] Buffered compare value moves to active register only at count top.
// [RL6] Software reaches the buffer when buffering, else the active register.
// [RL7] Outside PWM modes, force strobe updates wave output like a match, no flag, no clear.
// [RL8] A count write blocks all matches on the following tick.
// [RL9] Software avoids writing count equal to compare, or zero counting down.
// [RL10] Software sets wave state before making the pin an output.
// [RL11] Wave registers keep value across mode changes, reset clears them.
// [RL12] Action bits are not buffered, apply from next match.
// [RL13] Nonzero action makes wave output replace port data; direction kept.
// [RL14] Action zero leaves the wave register unchanged at matches.
// [RL15] Action bits never change the counting sequence.
// [RL16] Normal mode counts up only, wraps 0xFF to 0x00, writable anytime.
// [RL17] Normal mode sets overflow flag as count becomes zero.
// [RL18] Clear-on-compare mode clears count on tick after equal compare A.
// [RL19] Compare A below count is missed until count wraps past 0xFF.
// [RL20] Toggle action in clear-on-compare mode inverts wave each match.
// [RL21] Clear-on-compare overflow flag only on max to zero step.
// [RL22] Software count write beats any clear or count in same cycle.
// [RL23] Clock source zero stops ticks; count stays accessible.
// [RL24] Actions: 1 toggles, 2 clears, 3 sets wave output at match.
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int unsigned CNT_W = 8 // Counter width
)
(
  input wire logic core_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [tmc_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [tmc_pkg::AXI_DW-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [tmc_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [tmc_pkg::AXI_DW-1:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  input wire logic timer_tick_in, // Prescaler tick
  input wire logic ack_ovf, // Overflow irq serviced
  input wire logic ack_cmp_a, // Compare A irq serviced
  input wire logic ack_cmp_b, // Compare B irq serviced
  output logic irq_ovf, // Overflow request
  output logic irq_cmp_a, // Compare A request
  output logic irq_cmp_b, // Compare B request
  input wire logic port_data_a, // Port data, pin A
  input wire logic port_dir_a, // Port direction, pin A
  input wire logic port_data_b, // Port data, pin B
  input wire logic port_dir_b, // Port direction, pin B
  output logic pin_out_a, // Pin A level
  output logic pin_oe_a, // Pin A drive enable
  output logic pin_out_b, // Pin B level
  output logic pin_oe_b, // Pin B drive enable
  output logic wave_out_a, // Wave register A
  output logic wave_out_b // Wave register B
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 8) begin : g_bad_width
    $error("CNT_W must lie in 2..8");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_decode(input logic [AXI_AW-1:0] a);
    case (a)
      OFS_CTRL_A: reg_decode = IDX_CTRL_A;
      OFS_CTRL_B: reg_decode = IDX_CTRL_B;
      OFS_COUNT: reg_decode = IDX_COUNT;
      OFS_CMP_A: reg_decode = IDX_CMP_A;
      OFS_CMP_B: reg_decode = IDX_CMP_B;
      OFS_FLAGS: reg_decode = IDX_FLAGS;
      OFS_IRQ_EN: reg_decode = IDX_IRQ_EN;
      default: reg_decode = IDX_NONE;
    endcase
  endfunction : reg_decode

  // Odd mode codes are the PWM modes
  function automatic logic is_pwm(input logic [WGS_W-1:0] m);
    is_pwm = m[0];
  endfunction : is_pwm

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [WGS_W-1:0] wgs_r;
  logic [CSS_W-1:0] css_r;
  logic [ACT_W-1:0] act_r [2];
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cmp_act_r [2];
  logic [CNT_W-1:0] cmp_buf_r [2];
  logic ovf_r;
  logic [1:0] cflag_r;
  logic [2:0] irq_en_r;
  logic blk_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [AXI_DW-1:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [AXI_DW-1:0] rdata_r;
  logic [1:0] rresp_r;

  logic wr_go;
  logic wr_lane;
  logic [2:0] wr_idx;
  logic [CNT_W-1:0] wr_val;
  logic cnt_wr;
  logic tick;
  logic pwm;
  logic [CNT_W-1:0] top_val;
  logic at_top;
  logic ovf_set;
  logic [1:0] cmp_eq;
  logic [1:0] match_ev;
  logic [1:0] frc_ev;
  logic [1:0] ack_c;
  logic [1:0] pdat;
  logic [1:0] pdir;
  logic [1:0] pout;
  logic [1:0] poe;
  logic [1:0] wave;
  logic [AXI_DW-1:0] rd_val;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data taken in either order, write once both held
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign wr_go = aw_hold_r && w_hold_r;
  assign wr_idx = reg_decode(awaddr_r);
  assign wr_lane = wr_go && wstrb0_r;
  assign wr_val = wdata_r[CNT_W-1:0];
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Write address holding
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  // Write data holding
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_hold_r <= 1'b0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb0_r <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Read value, reserved bits zero
  always_comb begin
    rd_val = '0;
    case (reg_decode(s_axi_araddr))
      IDX_CTRL_A: begin
        rd_val[CA_ACT_A_LSB +: ACT_W] = act_r[0];
        rd_val[CA_ACT_B_LSB +: ACT_W] = act_r[1];
        rd_val[CA_WGS_LSB +: WGS_W] = wgs_r;
      end
      IDX_CTRL_B: rd_val[CB_CSS_LSB +: CSS_W] = css_r;
      IDX_COUNT: rd_val[CNT_W-1:0] = cnt_r;
      IDX_CMP_A: rd_val[CNT_W-1:0] = pwm ? cmp_buf_r[0] : cmp_act_r[0]; // RL6
      IDX_CMP_B: rd_val[CNT_W-1:0] = pwm ? cmp_buf_r[1] : cmp_act_r[1]; // RL6
      IDX_FLAGS: rd_val[2:0] = {cflag_r, ovf_r};
      IDX_IRQ_EN: rd_val[2:0] = irq_en_r;
      default: rd_val = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= (reg_decode(s_axi_araddr) == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Mode, actions, clock source, interrupt enables
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wgs_r <= RST_WGS;
      act_r[0] <= RST_ACT;
      act_r[1] <= RST_ACT;
      css_r <= RST_CSS;
      irq_en_r <= RST_IRQ_EN;
    end else if (wr_lane) begin
      if (wr_idx == IDX_CTRL_A) begin
        act_r[0] <= wdata_r[CA_ACT_A_LSB +: ACT_W]; // RL12
        act_r[1] <= wdata_r[CA_ACT_B_LSB +: ACT_W]; // RL12
        wgs_r <= wdata_r[CA_WGS_LSB +: WGS_W];
      end
      if (wr_idx == IDX_CTRL_B) begin
        css_r <= wdata_r[CB_CSS_LSB +: CSS_W];
      end
      if (wr_idx == IDX_IRQ_EN) begin
        irq_en_r <= wdata_r[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Tick gating, top selection; actions play no part here
  assign tick = timer_tick_in && (css_r != CSS_STOP); // RL23
  assign pwm = is_pwm(wgs_r);
  assign top_val = (wgs_r == WGS_CTC || (wgs_r[2] && pwm)) ? cmp_act_r[0] : CNT_MAX; // RL15
  assign at_top = (cnt_r == top_val);
  assign cnt_wr = wr_lane && (wr_idx == IDX_COUNT);

  // Count up, clear at top, software write first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (cnt_wr) begin
      cnt_r <= wr_val; // RL22 RL16
    end else if (tick) begin
      if (at_top) begin
        cnt_r <= '0; // RL18
      end else begin
        cnt_r <= cnt_r + 1'b1; // RL16 RL19
      end
    end
  end

  // Match blocking after a count write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blk_r <= 1'b0;
    end else if (cnt_wr) begin
      blk_r <= 1'b1; // RL8
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag
  // ----------------------------------------------------------------
  // Set on max to zero step; set beats clear
  assign ovf_set = tick && !cnt_wr && (cnt_r == CNT_MAX); // RL17 RL21
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovf_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_r <= 1'b1;
    end else if (ack_ovf || (wr_lane && wr_idx == IDX_FLAGS && wdata_r[FL_OVF])) begin
      ovf_r <= 1'b0;
    end
  end

  assign irq_ovf = ovf_r && irq_en_r[FL_OVF];

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  assign ack_c = {ack_cmp_b, ack_cmp_a};
  assign pdat = {port_data_b, port_data_a};
  assign pdir = {port_dir_b, port_dir_a};

  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic cmp_wr;
    logic flag_clr;

    assign cmp_wr = wr_lane && (wr_idx == IDX_CMP_A + 3'(i));
    assign cmp_eq[i] = (cnt_r == cmp_act_r[i]); // RL1
    assign match_ev[i] = tick && !blk_r && !cnt_wr && cmp_eq[i]; // RL8
    assign frc_ev[i] = wr_lane && (wr_idx == IDX_CTRL_B) &&
                       wdata_r[CB_FRC_A + i] && !pwm; // RL7
    assign flag_clr = ack_c[i] ||
                      (wr_lane && wr_idx == IDX_FLAGS && wdata_r[FL_CMP_A + i]);

    // Active and buffer compare registers
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cmp_act_r[i] <= '0;
        cmp_buf_r[i] <= '0;
      end else begin
        if (cmp_wr) begin
          cmp_buf_r[i] <= wr_val; // RL6
        end
        if (cmp_wr && !pwm) begin
          cmp_act_r[i] <= wr_val; // RL4
        end else if (pwm && tick && !cnt_wr && at_top) begin
          cmp_act_r[i] <= cmp_buf_r[i]; // RL5
        end
      end
    end

    // Compare flag; set beats clear, force never sets it
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cflag_r[i] <= 1'b0;
      end else if (match_ev[i]) begin
        cflag_r[i] <= 1'b1; // RL1
      end else if (flag_clr) begin
        cflag_r[i] <= 1'b0; // RL3
      end
    end

    tmc_wave_chan u_wave (
      .core_clk(core_clk),
      .rst(rst),
      .match_ev(match_ev[i]),
      .force_ev(frc_ev[i]),
      .action(act_r[i]),
      .port_data(pdat[i]),
      .port_dir(pdir[i]),
      .wave_out(wave[i]),
      .pin_out(pout[i]),
      .pin_oe(poe[i])
    );
  end

  // Per-channel outputs
  assign irq_cmp_a = cflag_r[0] && irq_en_r[FL_CMP_A]; // RL2
  assign irq_cmp_b = cflag_r[1] && irq_en_r[FL_CMP_A + 1]; // RL2
  assign wave_out_a = wave[0];
  assign wave_out_b = wave[1];
  assign pin_out_a = pout[0];
  assign pin_out_b = pout[1];
  assign pin_oe_a = poe[0];
  assign pin_oe_b = poe[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flag_on_match_a: assert property (@(posedge core_clk) disable iff (rst) // RL1
    tick && !blk_r && !cnt_wr && cnt_r == cmp_act_r[0] |=> cflag_r[0])
    else $error("compare flag A not set");

  irq_request_a: assert property (@(posedge core_clk) disable iff (rst) // RL2
    cflag_r[1] && irq_en_r[2] |-> irq_cmp_b)
    else $error("compare B request missing");

  ack_clears_a: assert property (@(posedge core_clk) disable iff (rst) // RL3
    ack_cmp_a && !match_ev[0] |=> !cflag_r[0])
    else $error("serviced flag A not cleared");

  direct_cmp_a: assert property (@(posedge core_clk) disable iff (rst) // RL4
    wr_lane && wr_idx == IDX_CMP_B && !pwm |=> cmp_act_r[1] == $past(wr_val))
    else $error("compare B not written directly");

  buffer_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RL5
    pwm && !(tick && at_top) ##1 pwm |-> $stable(cmp_act_r[0]))
    else $error("active compare moved off top");

  write_blocks_a: assert property (@(posedge core_clk) disable iff (rst) // RL8
    $rose(cflag_r[0]) |-> !$past(blk_r) && !$past(cnt_wr) && $past(tick))
    else $error("match not blocked after count write");

  normal_count_a: assert property (@(posedge core_clk) disable iff (rst) // RL16
    tick && !cnt_wr && wgs_r == WGS_NORMAL |=> cnt_r == CNT_W'($past(cnt_r) + 1'b1))
    else $error("normal mode count step wrong");

  overflow_set_a: assert property (@(posedge core_clk) disable iff (rst) // RL17
    tick && !cnt_wr && cnt_r == CNT_MAX |=> ovf_r && cnt_r == '0)
    else $error("overflow flag not set at wrap");

  ctc_clear_a: assert property (@(posedge core_clk) disable iff (rst) // RL18
    tick && !cnt_wr && wgs_r == WGS_CTC && cnt_r == cmp_act_r[0] |=> cnt_r == '0)
    else $error("count not cleared at compare A");

  cpu_priority_a: assert property (@(posedge core_clk) disable iff (rst) // RL22
    cnt_wr |=> cnt_r == $past(wr_val))
    else $error("count write lost");

  stopped_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RL23
    css_r == CSS_STOP && !cnt_wr |=> $stable(cnt_r))
    else $error("stopped counter moved");

endmodule : tmc_timer

// ### core/tmc_pkg.sv
/*
  Constants for the 8-bit timer compare block: register offsets, field
  positions, reset values, mode and action encodings, bus responses.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package tmc_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AXI_AW-1:0] OFS_CTRL_A = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_CTRL_B = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_COUNT = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_CMP_A = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_CMP_B = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_FLAGS = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_IRQ_EN = 8'h18;

  // Decoded register index
  localparam logic [2:0] IDX_CTRL_A = 3'h0;
  localparam logic [2:0] IDX_CTRL_B = 3'h1;
  localparam logic [2:0] IDX_COUNT = 3'h2;
  localparam logic [2:0] IDX_CMP_A = 3'h3;
  localparam logic [2:0] IDX_CMP_B = 3'h4;
  localparam logic [2:0] IDX_FLAGS = 3'h5;
  localparam logic [2:0] IDX_IRQ_EN = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int unsigned ACT_W = 2;
  localparam int unsigned WGS_W = 3;
  localparam int unsigned CSS_W = 3;
  localparam int unsigned CA_ACT_A_LSB = 0;
  localparam int unsigned CA_ACT_B_LSB = 2;
  localparam int unsigned CA_WGS_LSB = 4;
  localparam int unsigned CB_CSS_LSB = 0;
  localparam int unsigned CB_FRC_A = 3;
  localparam int unsigned FL_OVF = 0;
  localparam int unsigned FL_CMP_A = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [WGS_W-1:0] RST_WGS = 3'h0;
  localparam logic [CSS_W-1:0] RST_CSS = 3'h0;
  localparam logic [ACT_W-1:0] RST_ACT = 2'h0;
  localparam logic [2:0] RST_IRQ_EN = 3'h0;

  // ----------------------------------------------------------------
  // Modes and actions
  // ----------------------------------------------------------------
  localparam logic [WGS_W-1:0] WGS_NORMAL = 3'h0;
  localparam logic [WGS_W-1:0] WGS_CTC = 3'h2;
  localparam logic [CSS_W-1:0] CSS_STOP = 3'h0;
  localparam logic [ACT_W-1:0] ACT_NONE = 2'h0;
  localparam logic [ACT_W-1:0] ACT_TOGGLE = 2'h1;
  localparam logic [ACT_W-1:0] ACT_CLEAR = 2'h2;
  localparam logic [ACT_W-1:0] ACT_SET = 2'h3;

endpackage : tmc_pkg

// ### core/tmc_wave_chan.sv
/*
  One compare output channel: the wave output register and its pin
  override toward the general I/O port.
  Assumes match and force events are one-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
module tmc_wave_chan
  import tmc_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic match_ev, // Qualified compare match
  input wire logic force_ev, // Force strobe
  input wire logic [tmc_pkg::ACT_W-1:0] action, // Output action
  input wire logic port_data, // Port data bit
  input wire logic port_dir, // Port direction bit
  output logic wave_out, // Wave register
  output logic pin_out, // Pin level
  output logic pin_oe // Pin drive enable
);

  logic wave_r;

  // ----------------------------------------------------------------
  // Wave register
  // ----------------------------------------------------------------
  // Update on match or force, per action
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wave_r <= 1'b0; // RL11
    end else if (match_ev || force_ev) begin // RL7
      case (action) // RL12
        ACT_TOGGLE: wave_r <= ~wave_r; // RL24 RL20
        ACT_CLEAR: wave_r <= 1'b0; // RL24
        ACT_SET: wave_r <= 1'b1; // RL24
        default: wave_r <= wave_r; // RL14
      endcase
    end
  end

  // Pin override when any action bit set
  assign wave_out = wave_r;
  assign pin_out = (action != ACT_NONE) ? wave_r : port_data; // RL13
  assign pin_oe = port_dir; // RL13

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  toggle_on_ev_a: assert property (@(posedge core_clk) disable iff (rst) // RL24
    (match_ev || force_ev) && action == ACT_TOGGLE |=> wave_r != $past(wave_r))
    else $error("wave did not toggle");

  idle_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RL14
    action == ACT_NONE |=> $stable(wave_r))
    else $error("wave changed with no action");

  pin_override_a: assert property (@(posedge core_clk) disable iff (rst) // RL13
    action != ACT_NONE |-> pin_out == wave_out && pin_oe == port_dir)
    else $error("pin not overridden");

endmodule : tmc_wave_chan

// ### bench/tmc_port_model.sv
/*
  Port pin partner: data and direction bits, resolved pad level.
  Assumes the bench sets the port bits hierarchically.
*/
`timescale 1ns/1ps
module tmc_port_model (
  input wire logic pin_out_a, // Pin A level
  input wire logic pin_oe_a, // Pin A enable
  input wire logic pin_out_b, // Pin B level
  input wire logic pin_oe_b, // Pin B enable
  output logic port_data_a, // Data A
  output logic port_dir_a, // Dir A
  output logic port_data_b, // Data B
  output logic port_dir_b, // Dir B
  output logic pad_a, // Pad A
  output logic pad_b // Pad B
);
  // Released pads float to the pull-up
  assign pad_a = pin_oe_a ? pin_out_a : 1'b1;
  assign pad_b = pin_oe_b ? pin_out_b : 1'b1;
  // Port bits start as inputs
  initial begin
    port_data_a = 1'b0;
    port_dir_a = 1'b0;
    port_data_b = 1'b0;
    port_dir_b = 1'b0;
  end
endmodule : tmc_port_model

// ### bench/tb_tmc_timer.sv
/*
  Bench for the timer: AXI4-Lite tasks and directed scenarios.
  Assumes tmc_pkg offsets; ticks pulsed by the bench.
*/
`timescale 1ns/1ps
module tb_tmc_timer;
  import tmc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic tick = 1'b0, ack_a = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdt;
  logic awr, wrd, bv, arr, rv, irq_a, wave_a, pout_a, poe_a, pout_b, poe_b;
  logic pd_a, pdir_a, pd_b, pdir_b, pad_a, pad_b, irq_o, irq_b, wave_b;
  logic [1:0] br, rr;
  int n_mismatch = 0, compares = 0;
  // Clock
  always #2.5 core_clk = ~core_clk;
  // Design and partner
  tmc_timer u_tmc_timer (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdt), .s_axi_rresp(rr),
    .timer_tick_in(tick), .ack_ovf(1'b0), .ack_cmp_a(ack_a), .ack_cmp_b(1'b0),
    .irq_ovf(irq_o), .irq_cmp_a(irq_a), .irq_cmp_b(irq_b), .port_data_a(pd_a),
    .port_dir_a(pdir_a), .port_data_b(pd_b), .port_dir_b(pdir_b), .pin_out_a(pout_a),
    .pin_oe_a(poe_a), .pin_out_b(pout_b), .pin_oe_b(poe_b), .wave_out_a(wave_a),
    .wave_out_b(wave_b));
  tmc_port_model u_tmc_port_model (.pin_out_a(pout_a), .pin_oe_a(poe_a),
    .pin_out_b(pout_b), .pin_oe_b(poe_b), .port_data_a(pd_a), .port_dir_a(pdir_a),
    .port_data_b(pd_b), .port_dir_b(pdir_b), .pad_a(pad_a), .pad_b(pad_b));
  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Bus write, expects OKAY
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    brdy <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    brdy <= 1'b0;
    chk({30'h0, br}, {30'h0, RESP_OKAY});
  endtask : wr
  // Bus read with data and response compare
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge core_clk);
    arv <= 1'b1;
    ara <= a;
    rrdy <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rrdy <= 1'b0;
    chk(rdt, e);
    chk({30'h0, rr}, {30'h0, er});
  endtask : rd
  // Timer tick pulses
  task tk(input int n);
    repeat (n) begin
      @(posedge core_clk);
      tick <= 1'b1;
      @(posedge core_clk);
      tick <= 1'b0;
    end
    @(posedge core_clk);
  endtask : tk
  // Verdict
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Watchdog
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
  // Scenarios
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    chk({31'h0, wave_a}, 32'h0);
    chk({31'h0, pout_a}, {31'h0, pd_a});
    rd(OFS_CTRL_A, 32'h0, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    $display("test reset done");
    wr(OFS_IRQ_EN, 32'h7);
    wr(OFS_CMP_A, 32'h3);
    wr(OFS_CTRL_B, 32'h1);
    wr(OFS_COUNT, 32'h3);
    tk(1);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    rd(OFS_COUNT, 32'h4, RESP_OKAY);
    $display("test block done");
    wr(OFS_CMP_A, 32'h5);
    wr(OFS_CTRL_A, 32'h21);
    tk(2);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    rd(OFS_FLAGS, 32'h2, RESP_OKAY);
    chk({31'h0, wave_a}, 32'h1);
    chk({31'h0, pout_a}, 32'h1);
    chk({31'h0, irq_a}, 32'h1);
    @(posedge core_clk) ack_a <= 1'b1;
    @(posedge core_clk) ack_a <= 1'b0;
    @(posedge core_clk);
    chk({31'h0, irq_a}, 32'h0);
    wr(OFS_COUNT, 32'hfe);
    tk(2);
    rd(OFS_COUNT, 32'h0, RESP_OKAY);
    rd(OFS_FLAGS, 32'h1, RESP_OKAY);
    chk({31'h0, irq_o}, 32'h1);
    wr(OFS_FLAGS, 32'h1);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    $display("test ctc done");
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_COUNT, 32'h7);
    tk(2);
    rd(OFS_COUNT, 32'h7, RESP_OKAY);
    wr(OFS_CTRL_A, 32'h02);
    chk({31'h0, wave_a}, 32'h1);
    wr(OFS_CTRL_B, 32'h08);
    chk({31'h0, wave_a}, 32'h0);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    rd(OFS_COUNT, 32'h7, RESP_OKAY);
    @(posedge core_clk) u_tmc_port_model.port_dir_a <= 1'b1;
    @(posedge core_clk);
    chk({30'h0, poe_a, pad_a}, 32'h2);
    $display("test force done");
    wr(OFS_CTRL_A, 32'h00);
    wr(OFS_CMP_A, 32'h8);
    wr(OFS_CTRL_B, 32'h1);
    @(posedge core_clk) u_tmc_port_model.port_data_a <= 1'b1;
    tk(2);
    chk({30'h0, wave_a, pout_a}, 32'h1);
    rd(OFS_FLAGS, 32'h2, RESP_OKAY);
    rd(OFS_COUNT, 32'h9, RESP_OKAY);
    $display("test action done");
    wr(OFS_CTRL_A, 32'h0c);
    wr(OFS_CMP_B, 32'h9);
    tk(1);
    chk({28'h0, irq_b, wave_b, pout_b, pad_b}, 32'hf);
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_CTRL_A, 32'h70);
    wr(OFS_CMP_A, 32'hb);
    rd(OFS_CMP_A, 32'hb, RESP_OKAY);
    tk(2);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    wr(OFS_COUNT, 32'h8);
    tk(1);
    wr(OFS_CTRL_A, 32'h0);
    rd(OFS_CMP_A, 32'hb, RESP_OKAY);
    $display("test buffer done");
    give_verdict();
  end
endmodule : tb_tmc_timer
